// >>> rtl/power_event_source_log.sv
// cause log for power-up, wake and power-down events, with AHB-Lite slave
// assumes the power state machine gives one-cycle event pulses with causes valid alongside
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module power_event_source_log (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // events from the power state machine
  input wire logic on_event,
  input wire logic wake_event,
  input wire logic off_event,
  // on and wake causes
  input wire logic wake_by_low_supply,
  input wire logic wake_by_watchdog,
  input wire logic wake_by_software,
  input wire logic up_by_clock_alarm,
  input wire logic up_by_on_pin,
  input wire logic reset_by_converter_undervolt,
  input wire logic reset_by_software,
  input wire logic reset_by_hardware,
  input wire logic reset_by_watchdog,
  // off causes
  input wire logic down_by_internal_regulator_error,
  input wire logic down_by_sequence_failure,
  input wire logic down_by_gpio,
  input wire logic down_by_supply_threshold,
  input wire logic down_by_overtemperature,
  input wire logic down_by_software,
  input wire logic down_by_on_pin,
  // interrupt
  output logic irq
);

  typedef struct packed {
    logic [15:0] on_cause;
    logic [15:0] off_cause;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic wr_pend;
    logic wr_mask;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic addr_valid;
  logic [29:0] widx;
  logic [2:0] mask_now;
  logic wake_only;

  assign addr_valid = hsel && htrans[1] && hready;
  assign widx = haddr[31:2];
  assign wake_only = wake_event && !on_event;
  assign mask_now = (st_ff.wr_pend && st_ff.wr_mask) ? hwdata[2:0] : st_ff.irq_mask;

  always_comb begin
    nxt_st = st_ff;
    if (ce) begin
      // data phase of a write: only the mask is writable
      if (st_ff.wr_pend) begin
        if (st_ff.wr_mask) begin
          nxt_st.irq_mask = hwdata[2:0];
        end
        nxt_st.wr_pend = 1'b0;
        nxt_st.wr_mask = 1'b0;
      end
      nxt_st.hrdata = pwr_cause_pkg::RDATA_RESET;
      if (addr_valid && hwrite) begin
        // cause registers ignore writes
        nxt_st.wr_pend = 1'b1; // RQ11
        nxt_st.wr_mask = (widx == pwr_cause_pkg::IDX_IRQ_MASK);
      end
      if (addr_valid && !hwrite) begin
        unique case (widx)
          pwr_cause_pkg::IDX_ON_CAUSE: begin
            nxt_st.hrdata = {16'h0000, st_ff.on_cause};
          end
          pwr_cause_pkg::IDX_OFF_CAUSE: begin
            nxt_st.hrdata = {16'h0000, st_ff.off_cause};
          end
          pwr_cause_pkg::IDX_IRQ_STATUS: begin
            nxt_st.hrdata = {29'h00000000, st_ff.irq_status};
            nxt_st.irq_status = pwr_cause_pkg::IRQ_RESET;
          end
          pwr_cause_pkg::IDX_IRQ_MASK: begin
            nxt_st.hrdata = {29'h00000000, mask_now};
          end
          default: begin
            nxt_st.hrdata = pwr_cause_pkg::RDATA_RESET;
          end
        endcase
      end
      // new on or wake event replaces the whole on record
      if (on_event || wake_event) begin
        nxt_st.on_cause = pwr_cause_pkg::CAUSE_RESET; // RQ18 RQ19
        nxt_st.on_cause[pwr_cause_pkg::ON_ALARM_BIT] = up_by_clock_alarm; // RQ5
        nxt_st.on_cause[pwr_cause_pkg::ON_PIN_BIT] = up_by_on_pin; // RQ6
      end
      if (wake_only) begin
        nxt_st.on_cause[pwr_cause_pkg::ON_LOW_SUPPLY_BIT] = wake_by_low_supply; // RQ1 RQ2
        nxt_st.on_cause[pwr_cause_pkg::ON_WATCHDOG_BIT] = wake_by_watchdog; // RQ3
        nxt_st.on_cause[pwr_cause_pkg::ON_SOFTWARE_BIT] = wake_by_software; // RQ4
        nxt_st.irq_status[pwr_cause_pkg::IRQ_WAKE_BIT] = 1'b1;
      end
      if (on_event) begin
        nxt_st.on_cause[pwr_cause_pkg::ON_CONV_UV_BIT] = reset_by_converter_undervolt; // RQ7
        nxt_st.on_cause[pwr_cause_pkg::ON_SW_RESET_BIT] = reset_by_software; // RQ8
        nxt_st.on_cause[pwr_cause_pkg::ON_HW_RESET_BIT] = reset_by_hardware; // RQ9
        nxt_st.on_cause[pwr_cause_pkg::ON_WDOG_RESET_BIT] = reset_by_watchdog; // RQ10
        nxt_st.irq_status[pwr_cause_pkg::IRQ_ON_BIT] = 1'b1;
      end
      if (off_event) begin
        nxt_st.off_cause = pwr_cause_pkg::CAUSE_RESET; // RQ18 RQ19
        nxt_st.off_cause[pwr_cause_pkg::OFF_REG_ERR_BIT] =
          down_by_internal_regulator_error; // RQ12
        nxt_st.off_cause[pwr_cause_pkg::OFF_SEQ_FAIL_BIT] = down_by_sequence_failure; // RQ13
        nxt_st.off_cause[pwr_cause_pkg::OFF_GPIO_BIT] = down_by_gpio; // RQ14
        nxt_st.off_cause[pwr_cause_pkg::OFF_SUPPLY_BIT] = down_by_supply_threshold; // RQ15
        nxt_st.off_cause[pwr_cause_pkg::OFF_OVERTEMP_BIT] = down_by_overtemperature; // RQ16
        nxt_st.off_cause[pwr_cause_pkg::OFF_SOFTWARE_BIT] = down_by_software; // RQ17
        nxt_st.off_cause[pwr_cause_pkg::OFF_PIN_BIT] = down_by_on_pin; // RQ6
        nxt_st.irq_status[pwr_cause_pkg::IRQ_OFF_BIT] = 1'b1;
      end
      nxt_st.irq = |(nxt_st.irq_status & nxt_st.irq_mask);
      nxt_st.hreadyout = 1'b1;
      nxt_st.hresp = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff.on_cause <= pwr_cause_pkg::CAUSE_RESET; // RQ11
      st_ff.off_cause <= pwr_cause_pkg::CAUSE_RESET; // RQ11
      st_ff.irq_status <= pwr_cause_pkg::IRQ_RESET;
      st_ff.irq_mask <= pwr_cause_pkg::IRQ_RESET;
      st_ff.wr_pend <= 1'b0;
      st_ff.wr_mask <= 1'b0;
      st_ff.hrdata <= pwr_cause_pkg::RDATA_RESET;
      st_ff.hreadyout <= 1'b1;
      st_ff.hresp <= 1'b0;
      st_ff.irq <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata = st_ff.hrdata;
  assign hreadyout = st_ff.hreadyout;
  assign hresp = st_ff.hresp;
  assign irq = st_ff.irq;

  // checks
  low_supply_wake_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
    ce && wake_only |=> st_ff.on_cause[10] == $past(wake_by_low_supply))
    else $error("low supply wake bit wrong");
  low_supply_on_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ2
    ce && on_event |=> !st_ff.on_cause[10])
    else $error("low supply bit set on ON event");
  watchdog_wake_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
    ce && (on_event || wake_event) |=> st_ff.on_cause[7] == ($past(wake_by_watchdog)
      && !$past(on_event)))
    else $error("watchdog wake bit wrong");
  software_wake_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ4
    ce && wake_only |=> st_ff.on_cause[6] == $past(wake_by_software))
    else $error("software wake bit wrong");
  alarm_cause_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
    ce && (on_event || wake_event) |=> st_ff.on_cause[5] == $past(up_by_clock_alarm))
    else $error("alarm bit wrong");
  on_pin_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ6
    ce && off_event |=> st_ff.off_cause[4] == $past(down_by_on_pin))
    else $error("off pin bit wrong");
  conv_uv_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
    ce && on_event |=> st_ff.on_cause[3] == $past(reset_by_converter_undervolt))
    else $error("undervoltage bit wrong");
  sw_reset_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ8
    ce && on_event |=> st_ff.on_cause[2] == $past(reset_by_software))
    else $error("software reset bit wrong");
  hw_reset_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
    ce && on_event |=> st_ff.on_cause[1] == $past(reset_by_hardware))
    else $error("hardware reset bit wrong");
  wdog_reset_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ10
    ce && wake_only |=> st_ff.on_cause[3:0] == 4'h0)
    else $error("reset bits set on wake");
  no_write_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ11
    !(ce && (on_event || wake_event)) |=> $stable(st_ff.on_cause))
    else $error("on cause changed without event");
  off_faults_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ12
    ce && off_event |=> st_ff.off_cause[13:12] == {$past(down_by_internal_regulator_error),
      $past(down_by_sequence_failure)})
    else $error("regulator or sequence bit wrong");
  off_gpio_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ14
    ce && off_event |=> st_ff.off_cause[11] == $past(down_by_gpio))
    else $error("gpio off bit wrong");
  off_supply_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ15
    ce && off_event |=> st_ff.off_cause[10:9] == {$past(down_by_supply_threshold),
      $past(down_by_overtemperature)})
    else $error("supply or temperature bit wrong");
  off_software_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ17
    ce && off_event |=> st_ff.off_cause[6] == $past(down_by_software))
    else $error("software off bit wrong");
  off_stable_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ18
    !(ce && off_event) |=> $stable(st_ff.off_cause))
    else $error("off cause changed without event");
  reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ19
    ((st_ff.on_cause & ~pwr_cause_pkg::ON_DEFINED_MASK) == 16'h0000) &&
    ((st_ff.off_cause & ~pwr_cause_pkg::OFF_DEFINED_MASK) == 16'h0000))
    else $error("undefined cause bit set");
  off_seq_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ13
    ce && off_event && down_by_sequence_failure |=> st_ff.irq_status[2] && st_ff.off_cause[12])
    else $error("sequence failure not logged");
  on_wdog_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ10
    ce && on_event |=> st_ff.on_cause[0] == $past(reset_by_watchdog))
    else $error("watchdog reset bit wrong");
  over_temp_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ16
    ce && off_event && down_by_overtemperature |=> st_ff.off_cause[9])
    else $error("over-temperature not logged");
  on_pin_up_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ6
    ce && (on_event || wake_event) |=> st_ff.on_cause[4] == $past(up_by_on_pin))
    else $error("on pin bit wrong");
  freeze_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ11
    !ce |=> $stable(st_ff.on_cause) && $stable(st_ff.off_cause))
    else $error("cause changed while frozen");
  read_on_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ19
    ce && addr_valid && !hwrite && (widx == pwr_cause_pkg::IDX_ON_CAUSE)
      |=> hrdata == {16'h0000, $past(st_ff.on_cause)})
    else $error("on cause read data wrong");
  read_off_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ19
    ce && addr_valid && !hwrite && (widx == pwr_cause_pkg::IDX_OFF_CAUSE)
      |=> hrdata == {16'h0000, $past(st_ff.off_cause)})
    else $error("off cause read data wrong");
  write_drop_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ11
    ce && st_ff.wr_pend && !on_event && !wake_event && !off_event
      |=> $stable(st_ff.on_cause) && $stable(st_ff.off_cause))
    else $error("write reached a cause register");
  zero_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("slave not ready or not okay");
  status_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && off_event |=> st_ff.irq_status[pwr_cause_pkg::IRQ_OFF_BIT])
    else $error("off status not set");
  wake_status_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && wake_only |=> st_ff.irq_status[pwr_cause_pkg::IRQ_WAKE_BIT])
    else $error("wake status not set");

  wake_seen_c: cover property (@(posedge hclk) disable iff (!hresetn)
    ce && wake_only && wake_by_low_supply);
  on_seen_c: cover property (@(posedge hclk) disable iff (!hresetn)
    ce && on_event && reset_by_watchdog);
  off_seen_c: cover property (@(posedge hclk) disable iff (!hresetn)
    ce && off_event ##1 irq);
  status_read_c: cover property (@(posedge hclk) disable iff (!hresetn)
    ce && addr_valid && !hwrite && widx == pwr_cause_pkg::IDX_IRQ_STATUS && on_event);
  frozen_event_c: cover property (@(posedge hclk) disable iff (!hresetn)
    !ce && on_event);

endmodule : power_event_source_log

// >>> rtl/pwr_cause_pkg.sv
// constants for the power event cause log: bus indices, bit positions, resets
// assumes a word-wide AHB-Lite bus and a power state machine driving event pulses
// What this block does
// RQ1: wake by low supply sets on bit 10
// RQ2: low supply never marks an ON event
// RQ3: watchdog wake sets on bit 7
// RQ4: software wake sets on bit 6
// RQ5: clock alarm ON or WAKE sets bit 5
// RQ6: power-on pin sets bit 4 both registers
// RQ7: converter undervoltage reset sets on bit 3
// RQ8: software reset ON sets on bit 2
// RQ9: hardware reset ON sets on bit 1
// RQ10: watchdog reset ON sets on bit 0
// RQ11: flags reset to zero, writes ignored
// RQ12: internal regulator error sets off bit 13
// RQ13: sequence failure sets off bit 12
// RQ14: GPIO off request sets off bit 11
// RQ15: supply threshold crossing sets off bit 10
// RQ16: over-temperature sets off bit 9
// RQ17: software off sets off bit 6
// RQ18: new event replaces previous flags of class
// RQ19: undefined bits read zero, ignore writes
package pwr_cause_pkg;
  // register indices; byte address is four times the index
  localparam logic [29:0] IDX_ON_CAUSE = 30'h0000400E;
  localparam logic [29:0] IDX_OFF_CAUSE = 30'h0000400F;
  localparam logic [29:0] IDX_IRQ_STATUS = 30'h00004020;
  localparam logic [29:0] IDX_IRQ_MASK = 30'h00004021;
  // on-cause bit positions
  localparam int ON_LOW_SUPPLY_BIT = 10;
  localparam int ON_WATCHDOG_BIT = 7;
  localparam int ON_SOFTWARE_BIT = 6;
  localparam int ON_ALARM_BIT = 5;
  localparam int ON_PIN_BIT = 4;
  localparam int ON_CONV_UV_BIT = 3;
  localparam int ON_SW_RESET_BIT = 2;
  localparam int ON_HW_RESET_BIT = 1;
  localparam int ON_WDOG_RESET_BIT = 0;
  // off-cause bit positions
  localparam int OFF_REG_ERR_BIT = 13;
  localparam int OFF_SEQ_FAIL_BIT = 12;
  localparam int OFF_GPIO_BIT = 11;
  localparam int OFF_SUPPLY_BIT = 10;
  localparam int OFF_OVERTEMP_BIT = 9;
  localparam int OFF_SOFTWARE_BIT = 6;
  localparam int OFF_PIN_BIT = 4;
  // defined-bit masks
  localparam logic [15:0] ON_DEFINED_MASK = 16'h04FF;
  localparam logic [15:0] OFF_DEFINED_MASK = 16'h3E50;
  // interrupt status bits
  localparam int IRQ_ON_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  localparam int IRQ_OFF_BIT = 2;
  localparam int IRQ_WIDTH = 3;
  // reset values
  localparam logic [15:0] CAUSE_RESET = 16'h0000;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;
endpackage : pwr_cause_pkg

// >>> sim/power_event_source_log_test.sv
// bench for the power event cause log: bus reads and writes, event pulses, irq
// assumes the log answers as a zero-wait AHB-Lite slave; ce is held high except in the freeze test
`timescale 1ns/1ps
module power_event_source_log_test;
  localparam logic [29:0] ON_I = pwr_cause_pkg::IDX_ON_CAUSE;
  localparam logic [29:0] OFF_I = pwr_cause_pkg::IDX_OFF_CAUSE;
  localparam logic [29:0] ST_I = pwr_cause_pkg::IDX_IRQ_STATUS;
  localparam logic [29:0] MK_I = pwr_cause_pkg::IDX_IRQ_MASK;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [2:0] evk = 3'h0;
  logic [15:0] onc = 16'h0000;
  logic [15:0] offc = 16'h0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  int error_cnt = 0;
  int checks = 0;
  always #4 hclk = ~hclk;
  power_event_source_log i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp),
    .on_event(evk[0]), .wake_event(evk[1]), .off_event(evk[2]),
    .wake_by_low_supply(onc[10]), .wake_by_watchdog(onc[7]), .wake_by_software(onc[6]),
    .up_by_clock_alarm(onc[5]), .up_by_on_pin(onc[4]),
    .reset_by_converter_undervolt(onc[3]), .reset_by_software(onc[2]),
    .reset_by_hardware(onc[1]), .reset_by_watchdog(onc[0]),
    .down_by_internal_regulator_error(offc[13]), .down_by_sequence_failure(offc[12]),
    .down_by_gpio(offc[11]), .down_by_supply_threshold(offc[10]),
    .down_by_overtemperature(offc[9]), .down_by_software(offc[6]),
    .down_by_on_pin(offc[4]),
    .irq(irq)
  );
  // one single transfer, waits on hready in both phases
  task bus(input logic w, input logic [29:0] idx, input logic [31:0] wd,
           output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {idx, 2'h0};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task wr(input logic [29:0] idx, input logic [31:0] wd);
    logic [31:0] r;
    bus(1'b1, idx, wd, r);
  endtask : wr
  task rd_chk(input logic [29:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 32'h00000000, r);
    checks++;
    if (r !== exp || hresp !== 1'b0) begin
      error_cnt++;
      $display("unexpected at %0t: reg %h read %h not %h resp %b", $time, idx, r, exp, hresp);
    end
  endtask : rd_chk
  task irq_chk(input logic exp);
    @(posedge hclk);
    checks++;
    if (irq !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: irq %b not %b", $time, irq, exp);
    end
  endtask : irq_chk
  // k bits: 0 on, 1 wake, 2 off
  task ev(input logic [2:0] k, input logic [15:0] a, input logic [15:0] b);
    @(posedge hclk);
    evk <= k;
    onc <= a;
    offc <= b;
    @(posedge hclk);
    evk <= 3'h0;
  endtask : ev
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(ON_I, 32'h00000000);
    rd_chk(OFF_I, 32'h00000000);
    rd_chk(ST_I, 32'h00000000);
    rd_chk(MK_I, 32'h00000000);
    rd_chk(30'h00004030, 32'h00000000);
    irq_chk(1'b0);
    $display("test reset done");
    wr(MK_I, 32'h00000005);
    rd_chk(MK_I, 32'h00000005);
    ev(3'h1, 16'h04FF, 16'h0000);
    rd_chk(ON_I, 32'h0000003F);
    irq_chk(1'b1);
    rd_chk(ST_I, 32'h00000001);
    irq_chk(1'b0);
    ev(3'h2, 16'h04FF, 16'h0000);
    rd_chk(ON_I, 32'h000004F0);
    irq_chk(1'b0);
    rd_chk(ST_I, 32'h00000002);
    ev(3'h4, 16'h0000, 16'hFFFF);
    rd_chk(OFF_I, 32'h00003E50);
    rd_chk(ON_I, 32'h000004F0);
    irq_chk(1'b1);
    rd_chk(ST_I, 32'h00000004);
    $display("test all causes done");
    wr(ON_I, 32'hFFFFFFFF);
    wr(OFF_I, 32'h00000000);
    rd_chk(ON_I, 32'h000004F0);
    rd_chk(OFF_I, 32'h00003E50);
    $display("test writes done");
    ev(3'h1, 16'h0402, 16'h0000);
    rd_chk(ON_I, 32'h00000002);
    ev(3'h2, 16'h0080, 16'h0000);
    rd_chk(ON_I, 32'h00000080);
    ev(3'h4, 16'h0000, 16'h0040);
    rd_chk(OFF_I, 32'h00000040);
    ev(3'h3, 16'h0421, 16'h0000);
    rd_chk(ON_I, 32'h00000021);
    rd_chk(ST_I, 32'h00000007);
    $display("test replace done");
    @(posedge hclk);
    ce <= 1'b0;
    ev(3'h1, 16'h0002, 16'h0040);
    ce <= 1'b1;
    rd_chk(ON_I, 32'h00000021);
    rd_chk(ST_I, 32'h00000000);
    $display("test freeze done");
    wrap_up();
  end
  initial begin
    #(8 * 3000);
    error_cnt++;
    $display("unexpected at %0t: watchdog ran out", $time);
    wrap_up();
  end
endmodule : power_event_source_log_test
